//--- design/rdc_radio_disable.sv
// radio disable control with coexistence uart
// Behaviour
// - low disable input stops its radio
// - single host line: primary disables all radios
// - disable inputs synchronised before use
// - asserted input keeps mapped radios disabled
// - wind down traffic promptly after assertion
// - radio ceased within thirty seconds, regardless
// - indicator shows disabled once sequence completes
// - resume and indicate within one second
// - rf only when released and software enables
// - shared lines only sensed, never driven
// - coexistence transmit line is uart output
// - coexistence receive line is uart input
// - reserved pins left without function
`default_nettype none

module rdc_radio_disable
  import rdc_pkg::*;
#(
  parameter longint unsigned SHUTDOWN_LIMIT = SHUTDOWN_CYC,
  parameter int BAUD_DIV = UART_BAUD_DIV_DEF
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic primaryRfKill_n,
  input wire logic secondaryRfKill_n,
  input wire logic secondaryWired,
  input wire rdc_pkg::rdc_radio_ctl_t [rdc_pkg::NUM_RADIOS-1:0] radioCtl,
  output var rdc_pkg::rdc_radio_stat_t [rdc_pkg::NUM_RADIOS-1:0] radioStat,
  output logic radioIndicatorAOut,
  output logic radioIndicatorAOe,
  output logic radioIndicatorBOut,
  output logic radioIndicatorBOe,
  output logic coexistTxLine,
  input wire logic coexistRxLine,
  input wire logic coexistAuxIn,
  output logic coexistAuxOut,
  output logic coexistAuxOe,
  input wire logic [rdc_pkg::UART_DATA_BITS-1:0] coexTxData,
  input wire logic coexTxValid,
  output logic coexTxReady,
  output logic [rdc_pkg::UART_DATA_BITS-1:0] coexRxData,
  output logic coexRxValid,
  output logic coexRxFrameErr
);

  localparam int BW = $clog2(BAUD_DIV);
  localparam int NB = $clog2(UART_DATA_BITS);
  localparam logic [BW-1:0] BAUD_LAST = BW'(BAUD_DIV - 1);
  localparam logic [BW-1:0] BAUD_HALF = BW'(BAUD_DIV / 2);
  localparam logic [NB-1:0] BIT_LAST = NB'(UART_DATA_BITS - 1);
  localparam logic [SHUTDOWN_CNT_W-1:0] SHUT_LAST =
    SHUTDOWN_CNT_W'(SHUTDOWN_LIMIT - 1);

  function automatic logic baudTick(input logic [BW-1:0] cnt);
    return cnt == BAUD_LAST;
  endfunction : baudTick

  // ==========================================================================
  // input synchronisation
  logic [1:0] killSync_n;
  logic rxSync;

  rdc_sync #(.WIDTH(2), .RST_VAL(KILL_N_RST)) u_killSync (
    .clock(clock),
    .rst(rst),
    .d({secondaryRfKill_n, primaryRfKill_n}),
    .q(killSync_n)
  );

  rdc_sync #(.WIDTH(1), .RST_VAL(UART_IDLE_LVL)) u_rxSync (
    .clock(clock),
    .rst(rst),
    .d(coexistRxLine),
    .q(rxSync)
  );

  // ==========================================================================
  // strap capture and first evaluation
  logic strapTaken_r, strapTaken_nxt;
  logic useSecondary_r, useSecondary_nxt;
  logic [1:0] initCnt_r, initCnt_nxt;

  always_comb begin
    strapTaken_nxt = 1'b1;
    useSecondary_nxt = strapTaken_r ? useSecondary_r : secondaryWired;
    initCnt_nxt = initCnt_r;
    if (initCnt_r != INIT_CNT_DONE) begin
      initCnt_nxt = initCnt_r + 2'h1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strapTaken_r <= 1'b0;
      useSecondary_r <= 1'b0;
      initCnt_r <= INIT_CNT_RST;
    end else begin
      strapTaken_r <= strapTaken_nxt;
      useSecondary_r <= useSecondary_nxt;
      initCnt_r <= initCnt_nxt;
    end
  end

  // ==========================================================================
  // per-radio disable sequencing
  rdc_radio_state_t [NUM_RADIOS-1:0] rState_r, rState_nxt;
  logic [NUM_RADIOS-1:0][SHUTDOWN_CNT_W-1:0] timer_r, timer_nxt;
  rdc_radio_stat_t [NUM_RADIOS-1:0] stat_nxt;
  logic [NUM_RADIOS-1:0] released;
  logic [NUM_RADIOS-1:0] ledOn_nxt;
  logic [NUM_RADIOS-1:0] ledOn_r;

  always_comb begin
    released[RADIO_A] = killSync_n[0];
    released[RADIO_B] = useSecondary_r ? killSync_n[1] : killSync_n[0];
  end

  always_comb begin
    logic allow;
    allow = 1'b0;
    rState_nxt = rState_r;
    timer_nxt = timer_r;
    stat_nxt = '{default: STAT_RST};
    ledOn_nxt = '0;
    for (int r = 0; r < NUM_RADIOS; r++) begin
      allow = released[r] && radioCtl[r].swEnable;
      unique case (rState_r[r])
        RST_INIT: begin
          if (initCnt_r == INIT_CNT_DONE) begin
            rState_nxt[r] = allow ? RST_RUN : RST_HALT;
          end
        end
        RST_RUN: begin
          if (!allow) begin
            rState_nxt[r] = RST_WIND;
            timer_nxt[r] = '0;
          end
        end
        RST_WIND: begin
          timer_nxt[r] = timer_r[r] + SHUTDOWN_CNT_W'(1);
          if (allow) begin
            rState_nxt[r] = RST_RUN;
          end else if (radioCtl[r].graceDone) begin
            rState_nxt[r] = RST_HALT;
          end else if (timer_r[r] == SHUT_LAST) begin
            rState_nxt[r] = RST_HALT;
            stat_nxt[r].forcedHalt = 1'b1;
          end
        end
        RST_HALT: begin
          if (allow) begin
            rState_nxt[r] = RST_RUN;
            stat_nxt[r].resumeStart = 1'b1;
          end
        end
      endcase
      // outputs follow the state being entered
      stat_nxt[r].rfPermit = (rState_nxt[r] == RST_RUN) && allow;
      stat_nxt[r].windDown = rState_nxt[r] == RST_WIND;
      stat_nxt[r].halted = rState_nxt[r] == RST_HALT;
      if (rState_r[r] == RST_HALT && rState_nxt[r] == RST_HALT) begin
        stat_nxt[r].forcedHalt = radioStat[r].forcedHalt;
      end
      // lit while able to transmit, dark once disabling completes
      ledOn_nxt[r] = (rState_nxt[r] == RST_RUN) ||
                     (rState_nxt[r] == RST_WIND);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rState_r <= '{default: RST_INIT};
      timer_r <= '0;
      radioStat <= '{default: STAT_RST};
      ledOn_r <= '0;
    end else begin
      rState_r <= rState_nxt;
      timer_r <= timer_nxt;
      radioStat <= stat_nxt;
      ledOn_r <= ledOn_nxt;
    end
  end

  // open-drain indicators: sink low when lit, release otherwise
  always_comb begin
    radioIndicatorAOe = ledOn_r[RADIO_A];
    radioIndicatorBOe = ledOn_r[RADIO_B];
  end

  // ==========================================================================
  // fixed pin levels
  logic auxOut_r;
  logic auxOe_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      auxOut_r <= 1'b0;
      auxOe_r <= 1'b0;
    end else begin
      auxOut_r <= 1'b0;
      auxOe_r <= 1'b0;
    end
  end

  always_comb begin
    coexistAuxOut = auxOut_r;
    coexistAuxOe = auxOe_r;
    radioIndicatorAOut = auxOut_r;
    radioIndicatorBOut = auxOut_r;
  end

  // ==========================================================================
  // coexistence uart transmitter, 8n1
  rdc_uart_state_t txState_r, txState_nxt;
  logic [BW-1:0] txBaud_r, txBaud_nxt;
  logic [NB-1:0] txBit_r, txBit_nxt;
  logic [UART_DATA_BITS-1:0] txShift_r, txShift_nxt;
  logic txLine_r, txLine_nxt;
  logic txReady_r, txReady_nxt;

  always_comb begin
    txState_nxt = txState_r;
    txBaud_nxt = baudTick(txBaud_r) ? '0 : txBaud_r + BW'(1);
    txBit_nxt = txBit_r;
    txShift_nxt = txShift_r;
    txLine_nxt = txLine_r;
    unique case (txState_r)
      UST_IDLE: begin
        txBaud_nxt = '0;
        txLine_nxt = UART_IDLE_LVL;
        if (coexTxValid && txReady_r) begin
          txState_nxt = UST_START;
          txShift_nxt = coexTxData;
          txLine_nxt = 1'b0;
        end
      end
      UST_START: begin
        if (baudTick(txBaud_r)) begin
          txState_nxt = UST_DATA;
          txBit_nxt = '0;
          txLine_nxt = txShift_r[0];
        end
      end
      UST_DATA: begin
        if (baudTick(txBaud_r)) begin
          if (txBit_r == BIT_LAST) begin
            txState_nxt = UST_STOP;
            txLine_nxt = 1'b1;
          end else begin
            txBit_nxt = txBit_r + NB'(1);
            txShift_nxt = {1'b0, txShift_r[UART_DATA_BITS-1:1]};
            txLine_nxt = txShift_r[1];
          end
        end
      end
      UST_STOP: begin
        if (baudTick(txBaud_r)) begin
          txState_nxt = UST_IDLE;
        end
      end
    endcase
    txReady_nxt = txState_nxt == UST_IDLE;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txState_r <= UST_IDLE;
      txBaud_r <= '0;
      txBit_r <= '0;
      txShift_r <= '0;
      txLine_r <= UART_IDLE_LVL;
      txReady_r <= 1'b0;
    end else begin
      txState_r <= txState_nxt;
      txBaud_r <= txBaud_nxt;
      txBit_r <= txBit_nxt;
      txShift_r <= txShift_nxt;
      txLine_r <= txLine_nxt;
      txReady_r <= txReady_nxt;
    end
  end

  always_comb begin
    coexistTxLine = txLine_r;
    coexTxReady = txReady_r;
  end

  // ==========================================================================
  // coexistence uart receiver, mid-bit sampling
  rdc_uart_state_t rxState_r, rxState_nxt;
  logic [BW-1:0] rxBaud_r, rxBaud_nxt;
  logic [NB-1:0] rxBit_r, rxBit_nxt;
  logic [UART_DATA_BITS-1:0] rxShift_r, rxShift_nxt;
  logic [UART_DATA_BITS-1:0] rxData_r, rxData_nxt;
  logic rxValid_r, rxValid_nxt;
  logic rxErr_r, rxErr_nxt;

  always_comb begin
    rxState_nxt = rxState_r;
    rxBaud_nxt = baudTick(rxBaud_r) ? '0 : rxBaud_r + BW'(1);
    rxBit_nxt = rxBit_r;
    rxShift_nxt = rxShift_r;
    rxData_nxt = rxData_r;
    rxValid_nxt = 1'b0;
    rxErr_nxt = 1'b0;
    unique case (rxState_r)
      UST_IDLE: begin
        rxBaud_nxt = '0;
        if (!rxSync) begin
          rxState_nxt = UST_START;
        end
      end
      UST_START: begin
        if (rxBaud_r == BAUD_HALF) begin
          rxBaud_nxt = '0;
          rxBit_nxt = '0;
          // a glitch shorter than half a bit is dropped
          rxState_nxt = rxSync ? UST_IDLE : UST_DATA;
        end
      end
      UST_DATA: begin
        if (baudTick(rxBaud_r)) begin
          rxShift_nxt = {rxSync, rxShift_r[UART_DATA_BITS-1:1]};
          rxBit_nxt = rxBit_r + NB'(1);
          if (rxBit_r == BIT_LAST) begin
            rxState_nxt = UST_STOP;
          end
        end
      end
      UST_STOP: begin
        if (baudTick(rxBaud_r)) begin
          rxState_nxt = UST_IDLE;
          rxData_nxt = rxShift_r;
          rxValid_nxt = rxSync;
          rxErr_nxt = !rxSync;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxState_r <= UST_IDLE;
      rxBaud_r <= '0;
      rxBit_r <= '0;
      rxShift_r <= '0;
      rxData_r <= '0;
      rxValid_r <= 1'b0;
      rxErr_r <= 1'b0;
    end else begin
      rxState_r <= rxState_nxt;
      rxBaud_r <= rxBaud_nxt;
      rxBit_r <= rxBit_nxt;
      rxShift_r <= rxShift_nxt;
      rxData_r <= rxData_nxt;
      rxValid_r <= rxValid_nxt;
      rxErr_r <= rxErr_nxt;
    end
  end

  always_comb begin
    coexRxData = rxData_r;
    coexRxValid = rxValid_r;
    coexRxFrameErr = rxErr_r;
  end

endmodule : rdc_radio_disable

`default_nettype wire

//--- design/rdc_pkg.sv
// constants and carrier types for the radio disable control block
`default_nettype none

package rdc_pkg;

  // ==========================================================================
  // radios and clock
  localparam int NUM_RADIOS = 2;
  localparam int RADIO_A = 0;
  localparam int RADIO_B = 1;
  localparam longint unsigned CLK_FREQ_HZ = 64'd250_000_000;
  localparam int SYNC_STAGES = 2;

  // ==========================================================================
  // shutdown and resume deadlines
  localparam longint unsigned SHUTDOWN_TIME_S = 64'd30;
  localparam longint unsigned SHUTDOWN_CYC = SHUTDOWN_TIME_S * CLK_FREQ_HZ;
  localparam int SHUTDOWN_CNT_W = 33;
  localparam longint unsigned RESUME_TIME_S = 64'd1;
  localparam longint unsigned RESUME_CYC = RESUME_TIME_S * CLK_FREQ_HZ;

  // ==========================================================================
  // reset values
  localparam logic KILL_N_RST = 1'b0;
  localparam logic UART_IDLE_LVL = 1'b1;
  localparam logic [1:0] INIT_CNT_RST = 2'h0;
  localparam logic [1:0] INIT_CNT_DONE = 2'(SYNC_STAGES);

  // ==========================================================================
  // coexistence uart
  localparam int UART_DATA_BITS = 8;
  localparam int UART_BAUD_DIV_DEF = 16;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    RST_INIT = 2'b00,
    RST_RUN = 2'b01,
    RST_WIND = 2'b11,
    RST_HALT = 2'b10
  } rdc_radio_state_t;

  typedef enum logic [1:0] {
    UST_IDLE = 2'b00,
    UST_START = 2'b01,
    UST_DATA = 2'b11,
    UST_STOP = 2'b10
  } rdc_uart_state_t;

  typedef struct packed {
    logic swEnable;
    logic graceDone;
  } rdc_radio_ctl_t;

  typedef struct packed {
    logic rfPermit;
    logic windDown;
    logic halted;
    logic forcedHalt;
    logic resumeStart;
  } rdc_radio_stat_t;

  localparam rdc_radio_stat_t STAT_RST = '{default: 1'b0};

endpackage : rdc_pkg

`default_nettype wire

//--- design/rdc_sync.sv
// two-stage level synchroniser for asynchronous inputs
`default_nettype none

module rdc_sync #(
  parameter int WIDTH = 1,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output var logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= {WIDTH{RST_VAL}};
      q <= {WIDTH{RST_VAL}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : rdc_sync

`default_nettype wire

//--- tb/rdc_radio_disable_checker.sv
// port assertions for the radio disable control block
`default_nettype none

module rdc_radio_disable_checker
  import rdc_pkg::*;
#(
  parameter longint unsigned SHUTDOWN_LIMIT = SHUTDOWN_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic primaryRfKill_n,
  input wire rdc_pkg::rdc_radio_ctl_t [rdc_pkg::NUM_RADIOS-1:0] radioCtl,
  input wire rdc_pkg::rdc_radio_stat_t [rdc_pkg::NUM_RADIOS-1:0] radioStat,
  input wire logic radioIndicatorAOe,
  input wire logic radioIndicatorBOe,
  input wire logic radioIndicatorAOut,
  input wire logic radioIndicatorBOut,
  input wire logic coexistAuxOut,
  input wire logic coexistTxLine,
  input wire logic coexTxReady,
  input wire logic coexistAuxOe,
  input wire logic coexRxValid,
  input wire logic coexRxFrameErr
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WMAX = int'(SHUTDOWN_LIMIT) + 1;

  // ==========================================================================
  // radio control
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  AST_KILL: assert property (
    !$past(primaryRfKill_n, 3) |-> !radioStat[0].rfPermit)
    else $error("radio A allowed while its line was low");
  AST_PERMIT: assert property (
    radioStat[0].rfPermit |-> $past(radioCtl[0].swEnable))
    else $error("radio A allowed without software enable");
  // release in the same cycle wins over a finished disassociation
  AST_GRACE: assert property (
    radioStat[0].windDown && radioCtl[0].graceDone &&
      (!radioCtl[0].swEnable || !$past(primaryRfKill_n, 2))
      |=> radioStat[0].halted)
    else $error("graceful end did not halt radio A");
  AST_TIMEOUT: assert property (
    $rose(radioStat[0].windDown) |-> ##[1:WMAX] !radioStat[0].windDown)
    else $error("radio A wind down overran its deadline");
  AST_HALT_LED: assert property (
    radioStat[0].halted |-> !radioIndicatorAOe)
    else $error("indicator A lit while halted");
  AST_LED_B: assert property (
    radioStat[1].rfPermit |-> radioIndicatorBOe)
    else $error("indicator B dark while radio B allowed");
  AST_RESUME: assert property (
    radioStat[0].resumeStart |-> radioStat[0].rfPermit
      && $past(radioStat[0].halted))
    else $error("resume pulse without leaving halt");

  // ==========================================================================
  // coexistence lines
  AST_TX_IDLE: assert property (
    coexTxReady |-> coexistTxLine)
    else $error("transmit line low while ready");
  AST_RX_PULSE: assert property (
    coexRxValid |-> !coexRxFrameErr ##1 !coexRxValid)
    else $error("receive valid not a clean single pulse");
  AST_NODRIVE: assert property (
    !coexistAuxOe && !coexistAuxOut && !radioIndicatorAOut &&
      !radioIndicatorBOut)
    else $error("aux line or indicator data driven");

  CV_RESUME: cover property (radioStat[0].resumeStart);
  CV_FORCED: cover property (radioStat[0].forcedHalt);
  CV_RX: cover property (coexRxValid);
endmodule : rdc_radio_disable_checker

`default_nettype wire

//--- tb/rdc_host_model.sv
// host switch lines and far coexistence radio, which echoes frames
`default_nettype none

module rdc_host_model (
  input wire logic clock,
  input wire logic [1:0] killReq,
  input wire logic coexistTxLine,
  output logic primaryRfKill_n,
  output logic secondaryRfKill_n,
  output logic coexistRxLine
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    primaryRfKill_n = 1'b1;
    secondaryRfKill_n = 1'b1;
    coexistRxLine = 1'b1;
  end

  // clean levels, moved off the clock edge to look asynchronous
  always @(posedge clock) begin
    #2;
    primaryRfKill_n <= killReq[0];
    secondaryRfKill_n <= killReq[1];
    coexistRxLine <= coexistTxLine;
  end
endmodule : rdc_host_model

`default_nettype wire

//--- tb/rdc_radio_disable_tb.sv
// self-checking testbench for the radio disable control block
`default_nettype none

module rdc_radio_disable_tb;
  import rdc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM = 50;
  localparam int BD = 8;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b1;
  logic [1:0] killReq = 2'h3;
  logic k1n, k2n, txL, rxL, ledA, ledB, txRdy, rxV;
  logic txV = 1'b0;
  logic [7:0] txD = 8'h00;
  logic [7:0] rxD;
  rdc_radio_ctl_t [NUM_RADIOS-1:0] ctl = '1;
  rdc_radio_stat_t [NUM_RADIOS-1:0] st;
  int n_errors = 0;
  int samples_checked = 0;
  logic [7:0] sent[$];

  rdc_radio_disable #(.SHUTDOWN_LIMIT(LIM), .BAUD_DIV(BD))
    rdc_radio_disable_inst (.clock(clock), .rst(rst),
    .primaryRfKill_n(k1n), .secondaryRfKill_n(k2n),
    .secondaryWired(strap), .radioCtl(ctl), .radioStat(st),
    .radioIndicatorAOut(), .radioIndicatorAOe(ledA),
    .radioIndicatorBOut(), .radioIndicatorBOe(ledB),
    .coexistTxLine(txL), .coexistRxLine(rxL), .coexistAuxIn(1'b0),
    .coexistAuxOut(), .coexistAuxOe(), .coexTxData(txD),
    .coexTxValid(txV), .coexTxReady(txRdy), .coexRxData(rxD),
    .coexRxValid(rxV), .coexRxFrameErr());

  rdc_host_model rdc_host_model_inst (.clock(clock), .killReq(killReq),
    .coexistTxLine(txL), .primaryRfKill_n(k1n),
    .secondaryRfKill_n(k2n), .coexistRxLine(rxL));

  initial begin
    forever #2 clock = ~clock;
  end

  // ==========================================================================
  // shared tasks
  function automatic logic mdl(input int lineUp, input int swOn);
    return logic'(lineUp != 0 && swOn != 0);
  endfunction : mdl

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic chkb(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %b got %b", nm, e, g);
    end
  endtask : chkb

  task automatic chkd(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chkd

  task automatic rstDut();
    rst = 1'b1;
    step(2);
    chkb("rstPermit", 1'b0, st[0].rfPermit);
    chkb("rstTx", 1'b1, txL);
    rst = 1'b0;
    step(1);
    chkb("initPermit", 1'b0, st[0].rfPermit);
    step(4);
  endtask : rstDut

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    #20000;
    n_errors++;
    complete_run();
  end

  // ==========================================================================
  // tests
  initial begin
    logic seen;
    void'($urandom(18214));
    rstDut();
    for (int i = 0; i < 4; i++) begin
      killReq = {i[0], i[1]};
      ctl[0].swEnable = i[0];
      ctl[1].swEnable = i[1];
      step(6);
      chkb("permitA", mdl(i / 2, i % 2), st[0].rfPermit);
      chkb("permitB", mdl(i % 2, i / 2), st[1].rfPermit);
      chkb("ledA", mdl(i / 2, i % 2), ledA);
      chkb("ledB", mdl(i % 2, i / 2), ledB);
    end
    $display("test table done");
    ctl[0].graceDone = 1'b0;
    killReq[0] = 1'b0;
    step(4);
    chkb("windDown", 1'b1, st[0].windDown);
    chkb("ledWind", 1'b1, ledA);
    step(LIM + 2);
    chkb("halted", 1'b1, st[0].halted);
    chkb("forced", 1'b1, st[0].forcedHalt);
    chkb("ledHalt", 1'b0, ledA);
    killReq[0] = 1'b1;
    seen = 1'b0;
    for (int j = 0; j < 8; j++) begin
      step(1);
      seen = seen | (st[0].resumeStart === 1'b1);
    end
    chkb("resume", 1'b1, seen);
    chkb("permitBack", 1'b1, st[0].rfPermit);
    killReq[0] = 1'b0;
    step(4);
    chkb("windAgain", 1'b1, st[0].windDown);
    killReq[0] = 1'b1;
    seen = 1'b0;
    for (int j = 0; j < 6; j++) begin
      step(1);
      seen = seen | (st[0].resumeStart === 1'b1);
    end
    chkb("windBack", 1'b1, st[0].rfPermit);
    chkb("noResume", 1'b0, seen);
    ctl[0].graceDone = 1'b1;
    $display("test deadline done");
    strap = 1'b0;
    rstDut();
    killReq = 2'b01;
    step(6);
    chkb("oneLineOn", 1'b1, st[1].rfPermit);
    killReq = 2'b10;
    step(6);
    chkb("oneLineOff", 1'b0, st[1].rfPermit);
    $display("test single line done");
    for (int n = 0; n < 4; n++) begin
      for (int j = 0; j < 200 && txRdy !== 1'b1; j++) step(1);
      chkb("txIdle", 1'b1, txL);
      txD = 8'($urandom);
      sent.push_back(txD);
      txV = 1'b1;
      step(1);
      txV = 1'b0;
      seen = 1'b0;
      for (int j = 0; j < 12 * BD + 20 && !seen; j++) begin
        step(1);
        seen = (rxV === 1'b1);
      end
      chkb("rxValid", 1'b1, seen);
      chkd("rxData", sent.pop_front(), rxD);
    end
    $display("test uart done");
    complete_run();
  end
endmodule : rdc_radio_disable_tb

bind rdc_radio_disable rdc_radio_disable_checker #(
  .SHUTDOWN_LIMIT(SHUTDOWN_LIMIT)
) rdc_radio_disable_checker_inst (.clock, .rst, .primaryRfKill_n,
  .radioCtl, .radioStat, .radioIndicatorAOe, .radioIndicatorBOe,
  .radioIndicatorAOut, .radioIndicatorBOut, .coexistAuxOut,
  .coexistTxLine, .coexTxReady, .coexistAuxOe,
  .coexRxValid, .coexRxFrameErr);

`default_nettype wire
